// ===== shared/tcl_pkg.sv
// Purpose: Constants for the tester control latch bank
// Assumes: 20 MHz system clock
// Notes:   Latch groups are three bits wide, eight groups in all
package tcl_pkg;
    // Clock
    localparam int CLOCK_PERIOD_NS = 50;

    // Setup word layout
    localparam int WORD_W        = 8;
    localparam int GROUP_SEL_HI  = 5;
    localparam int GROUP_SEL_LO  = 3;
    localparam int GROUP_VAL_HI  = 2;
    localparam int GROUP_VAL_LO  = 0;
    localparam int GROUP_W       = 3;
    localparam int GROUP_COUNT   = 8;

    // Shared-memory address of the setup word, presented by pull-ups
    localparam int          ADDR_W             = 11;
    localparam logic [10:0] LATCH_SETUP_WORD_ADDR = 11'h7FF;

    // Group indices
    localparam logic [2:0] GRP_CLOCK_RATE = 3'h0;
    localparam logic [2:0] GRP_DRIVE      = 3'h1;
    localparam logic [2:0] GRP_MODE       = 3'h2;
    localparam logic [2:0] GRP_RESET_DIV  = 3'h3;
    localparam logic [2:0] GRP_TRANSFER   = 3'h4;
    localparam logic [2:0] GRP_POWER      = 3'h5;
    localparam logic [2:0] GRP_RESULT     = 3'h6;
    localparam logic [2:0] GRP_STROBE     = 3'h7;

    // Bit positions inside a group
    localparam int BIT_HI  = 2;
    localparam int BIT_MID = 1;
    localparam int BIT_LO  = 0;

    // Reset image, group 7 in the top bits: drivers off, part held in reset
    localparam logic [23:0] LATCH_RESET = 24'h586070;

    // Oscillator periods in system clocks per rate code
    localparam logic [6:0] OSC_PER_0P25 = 7'h50;
    localparam logic [6:0] OSC_PER_0P5  = 7'h28;
    localparam logic [6:0] OSC_PER_1    = 7'h14;
    localparam logic [6:0] OSC_PER_2    = 7'h0A;
    localparam logic [6:0] OSC_PER_4    = 7'h05;

    // Prescale ratios
    localparam logic [5:0] DIV_32 = 6'h20;
    localparam logic [5:0] DIV_16 = 6'h10;
    localparam logic [5:0] DIV_8  = 6'h08;
    localparam logic [5:0] DIV_4  = 6'h04;

    // Bit strobe delays, least times rounded up
    localparam int STROBE_FAST_NS = 200;
    localparam int STROBE_SLOW_NS = 1000;
    localparam int STROBE_FAST_CYC = (STROBE_FAST_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int STROBE_SLOW_CYC = (STROBE_SLOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // Fixed trace clock, 0.5 MHz
    localparam int TRACE_PERIOD_NS  = 2000;
    localparam int TRACE_HALF_CYC   = TRACE_PERIOD_NS / CLOCK_PERIOD_NS / 2;
endpackage : tcl_pkg

// ===== design/tcl_bit_timing.sv
// Purpose: Oscillator, bit clock and delayed bit strobe generation
// Assumes: One system clock domain
// Notes:   Rates are integer divisions of the system clock
`timescale 1ns/10ps
`default_nettype none
module tcl_bit_timing (
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       run,
    input  wire logic [2:0] rate_sel,
    input  wire logic [1:0] prescale_sel,
    input  wire logic       slow_strobe,
    input  wire logic       doubled,
    output logic            osc_clk,
    output logic            bit_clk,
    output logic            bit_strobe
);
    logic [6:0]  osc_cnt;
    logic [6:0]  osc_per;
    logic [5:0]  div;
    logic [5:0]  bit_cnt;
    logic        osc_tick;
    logic        bit_rise;
    logic        half_rise;
    logic [tcl_pkg::STROBE_SLOW_CYC-1:0] pipe;

    // Rate code to oscillator period; top codes are the low-power rates
    always_comb begin
        case (rate_sel)
            3'h0:    osc_per = tcl_pkg::OSC_PER_0P25;
            3'h1:    osc_per = tcl_pkg::OSC_PER_0P5;
            3'h2:    osc_per = tcl_pkg::OSC_PER_1;
            3'h3:    osc_per = tcl_pkg::OSC_PER_2;
            3'h4:    osc_per = tcl_pkg::OSC_PER_4;
            3'h5:    osc_per = tcl_pkg::OSC_PER_1;
            3'h6:    osc_per = tcl_pkg::OSC_PER_2;
            default: osc_per = tcl_pkg::OSC_PER_0P25; // Unused code, slowest rate
        endcase
    end

    // Prescale code to bit-clock divider
    always_comb begin
        case (prescale_sel)
            2'h0:    div = tcl_pkg::DIV_32;
            2'h1:    div = tcl_pkg::DIV_16;
            2'h2:    div = tcl_pkg::DIV_8;
            default: div = tcl_pkg::DIV_4;
        endcase
    end

    assign osc_tick  = (osc_cnt >= osc_per - 7'h01);
    assign bit_rise  = osc_tick && (bit_cnt >= div - 6'h01);
    assign half_rise = osc_tick && (bit_cnt == (div >> 1) - 6'h01);

    // Oscillator counter; a rate change applies at once, to the period in progress
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            osc_cnt <= 7'h00;
            osc_clk <= 1'b0;
        end else if (!run) begin
            osc_cnt <= 7'h00;
            osc_clk <= 1'b0;
        end else begin
            osc_cnt <= osc_tick ? 7'h00 : osc_cnt + 7'h01;
            osc_clk <= osc_tick || (osc_cnt + 7'h01 < (osc_per >> 1));
        end
    end

    // Bit clock divider
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt <= 6'h00;
            bit_clk <= 1'b0;
        end else if (!run) begin
            bit_cnt <= 6'h00;
            bit_clk <= 1'b0;
        end else if (osc_tick) begin
            bit_cnt <= bit_rise ? 6'h00 : bit_cnt + 6'h01;
            bit_clk <= bit_rise || (bit_cnt + 6'h01 < (div >> 1));
        end
    end

    // Strobe delay line; a shift line lets two strobes per bit overlap
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pipe       <= '0;
            bit_strobe <= 1'b0;
        end else begin
            pipe <= {pipe[tcl_pkg::STROBE_SLOW_CYC-2:0], bit_rise || (doubled && half_rise)};
            // Tap at the full count so the strobe lags the bit clock by the whole delay
            bit_strobe <= slow_strobe ? pipe[tcl_pkg::STROBE_SLOW_CYC-1]
                                      : pipe[tcl_pkg::STROBE_FAST_CYC-1];
        end
    end
endmodule : tcl_bit_timing
`default_nettype wire

// ===== design/tcl_latch_bank.sv
// Purpose: Tester control latch bank with decoded control outputs
// Assumes: Host strobe and reset lines are synchronous to CLOCK
// Notes:   Latches load only while board and part are both in reset
`timescale 1ns/10ps
`default_nettype none
module tcl_latch_bank (
    input  wire logic        CLOCK,
    input  wire logic        ARST_N,
    input  wire logic        HOST_TARGET_RESET_N,
    input  wire logic        HOST_SYSTEM_RESET_N,
    input  wire logic        LATCH_STROBE,
    input  wire logic [7:0]  SHARED_DATA,
    input  wire logic        HALF_SPEED_FLAG_N,
    input  wire logic        START_SWITCH_STATE,
    input  wire logic        COMPARE_ERROR,
    input  wire logic        TARGET_RESET_IN,
    output logic [10:0]      ADDR_OUT,
    output logic             ADDR_OE_N,
    output logic             OSC_INPUT_PIN,
    output logic             OSC_OUTPUT_PIN_OUT,
    output logic             OSC_OUTPUT_PIN_OE_N,
    output logic             TARGET_RESET_N_OUT,
    output logic             TARGET_RESET_OE_N,
    output logic             L_IN_DRIVE_OE_N,
    output logic             SERIAL_BIT_CLOCK,
    output logic             TESTER_BIT_STROBE,
    output logic             D0_OUT,
    output logic             D0_OE_N,
    output logic [3:0]       EVENT_OUT,
    output logic             TRACE_CLOCK,
    output logic             SKIP_LINE,
    output logic             COMPARE_MODE,
    output logic             TRANSFER_ACTIVE,
    output logic             VERIFY_MODE,
    output logic             TESTER_MEM_WRITE,
    output logic             TESTER_MEM_VERIFY,
    output logic [7:0]       TESTER_MEM_DATA,
    output logic             SUPPLY_ON,
    output logic             SUPPLY_LOW_V,
    output logic             GOOD_PART,
    output logic             BAD_PART,
    output logic             TEST_DONE
);
    logic [2:0]  group_val [tcl_pkg::GROUP_COUNT];
    logic        strobe_q;
    logic        load_ok;
    logic        board_rst;
    logic        target_rst_hold;
    logic [2:0]  sel;
    logic [2:0]  val;
    logic        osc_clk;
    logic        bit_clk;
    logic        bit_strobe;
    logic        run;
    logic [10:0] pc;
    logic [5:0]  trace_cnt;
    logic        trace_clk;

    // Named latch fields
    logic [2:0]  clock_rate_select;
    logic        drive_enable_n;
    logic        osc_input_float_n;
    logic        event_route_select;
    logic        compare_select;
    logic        sync_delayed;
    logic        group_sync_n;
    logic        target_reset_n;
    logic [1:0]  prescale_select;
    logic        address_gen_clear_n;
    logic        transfer_mode_n;
    logic        verify_not_write;
    logic        retention_supply;
    logic        supply_and_clock_on;
    logic        second_clock_test;
    logic        pass_n;
    logic        fail_n;
    logic        test_done;
    logic        slow_strobe_part;
    logic        reset_float_n;
    logic        doubled_strobe_mode;

    // Field picker shared by all single-bit fields
    function automatic logic pick(input logic [2:0] g, input int pos);
        pick = g[pos];
    endfunction : pick

    // Board and target reset conditions
    assign board_rst       = !HOST_TARGET_RESET_N;
    assign target_rst_hold = !target_reset_n || !HOST_SYSTEM_RESET_N;
    assign load_ok         = board_rst && target_rst_hold;

    // Word decode: the two top bits carry nothing
    assign sel = SHARED_DATA[tcl_pkg::GROUP_SEL_HI:tcl_pkg::GROUP_SEL_LO];
    assign val = SHARED_DATA[tcl_pkg::GROUP_VAL_HI:tcl_pkg::GROUP_VAL_LO];

    // Strobe history for rising-edge capture
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= LATCH_STROBE;
        end
    end

    // One latch per group; only the addressed group takes the word
    generate
        for (genvar g = 0; g < tcl_pkg::GROUP_COUNT; g++) begin : g_latch
            always_ff @(posedge CLOCK or negedge ARST_N) begin
                if (!ARST_N) begin
                    group_val[g] <= tcl_pkg::LATCH_RESET[g*tcl_pkg::GROUP_W +: tcl_pkg::GROUP_W];
                end else if (load_ok && LATCH_STROBE && !strobe_q
                             && sel == 3'(g)) begin
                    group_val[g] <= val;
                end
            end
        end
    endgenerate

    // Field views
    assign clock_rate_select   = group_val[tcl_pkg::GRP_CLOCK_RATE];
    assign drive_enable_n      = pick(group_val[tcl_pkg::GRP_DRIVE], tcl_pkg::BIT_HI);
    assign osc_input_float_n   = pick(group_val[tcl_pkg::GRP_DRIVE], tcl_pkg::BIT_MID);
    assign event_route_select  = pick(group_val[tcl_pkg::GRP_DRIVE], tcl_pkg::BIT_LO);
    assign compare_select      = pick(group_val[tcl_pkg::GRP_MODE], tcl_pkg::BIT_HI);
    assign sync_delayed        = pick(group_val[tcl_pkg::GRP_MODE], tcl_pkg::BIT_MID);
    assign group_sync_n        = pick(group_val[tcl_pkg::GRP_MODE], tcl_pkg::BIT_LO);
    assign target_reset_n      = pick(group_val[tcl_pkg::GRP_RESET_DIV], tcl_pkg::BIT_HI);
    assign prescale_select     = group_val[tcl_pkg::GRP_RESET_DIV][tcl_pkg::BIT_MID:tcl_pkg::BIT_LO];
    assign address_gen_clear_n = pick(group_val[tcl_pkg::GRP_TRANSFER], tcl_pkg::BIT_HI);
    assign transfer_mode_n     = pick(group_val[tcl_pkg::GRP_TRANSFER], tcl_pkg::BIT_MID);
    assign verify_not_write    = pick(group_val[tcl_pkg::GRP_TRANSFER], tcl_pkg::BIT_LO);
    assign retention_supply    = pick(group_val[tcl_pkg::GRP_POWER], tcl_pkg::BIT_HI);
    assign supply_and_clock_on = pick(group_val[tcl_pkg::GRP_POWER], tcl_pkg::BIT_MID);
    assign second_clock_test   = pick(group_val[tcl_pkg::GRP_POWER], tcl_pkg::BIT_LO);
    assign pass_n              = pick(group_val[tcl_pkg::GRP_RESULT], tcl_pkg::BIT_HI);
    assign fail_n              = pick(group_val[tcl_pkg::GRP_RESULT], tcl_pkg::BIT_MID);
    assign test_done           = pick(group_val[tcl_pkg::GRP_RESULT], tcl_pkg::BIT_LO);
    assign slow_strobe_part    = pick(group_val[tcl_pkg::GRP_STROBE], tcl_pkg::BIT_HI);
    assign reset_float_n       = pick(group_val[tcl_pkg::GRP_STROBE], tcl_pkg::BIT_MID);
    assign doubled_strobe_mode = pick(group_val[tcl_pkg::GRP_STROBE], tcl_pkg::BIT_LO);

    // Timing runs whenever supply and clock are applied to the part
    assign run = supply_and_clock_on;

    tcl_bit_timing u_timing (
        .clock        (CLOCK),
        .arst_n       (ARST_N),
        .run          (run),
        .rate_sel     (clock_rate_select),
        .prescale_sel (prescale_select),
        .slow_strobe  (slow_strobe_part),
        .doubled      (doubled_strobe_mode),
        .osc_clk      (osc_clk),
        .bit_clk      (bit_clk),
        .bit_strobe   (bit_strobe)
    );

    // Pseudo program counter; held clear through board reset
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            pc <= 11'h000;
        end else if (board_rst || !address_gen_clear_n) begin
            pc <= 11'h000;
        end else if (bit_strobe) begin
            pc <= pc + 11'h001;
        end
    end

    // Address pins float during board reset so the pull-ups win
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ADDR_OUT  <= tcl_pkg::LATCH_SETUP_WORD_ADDR;
            ADDR_OE_N <= 1'b1;
        end else begin
            ADDR_OUT  <= board_rst ? tcl_pkg::LATCH_SETUP_WORD_ADDR : pc;
            ADDR_OE_N <= board_rst;
        end
    end

    // Fixed trace clock for the synchronisation trace
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            trace_cnt <= 6'h00;
            trace_clk <= 1'b0;
        end else if (trace_cnt >= 6'(tcl_pkg::TRACE_HALF_CYC - 1)) begin
            trace_cnt <= 6'h00;
            trace_clk <= !trace_clk;
        end else begin
            trace_cnt <= trace_cnt + 6'h01;
        end
    end

    // Event routing onto the trace lines
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            EVENT_OUT   <= 4'h0;
            TRACE_CLOCK <= 1'b0;
        end else if (!event_route_select) begin
            EVENT_OUT   <= {!osc_clk, osc_clk, !bit_clk, !bit_strobe};
            TRACE_CLOCK <= trace_clk;
        end else begin
            EVENT_OUT   <= {HALF_SPEED_FLAG_N, osc_clk, START_SWITCH_STATE, COMPARE_ERROR};
            TRACE_CLOCK <= !bit_strobe;
        end
    end

    // Oscillator pin drive; float wins, then retention supply, then sync
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            OSC_OUTPUT_PIN_OUT  <= 1'b0;
            OSC_OUTPUT_PIN_OE_N <= 1'b1;
        end else if (osc_input_float_n) begin
            OSC_OUTPUT_PIN_OUT  <= 1'b0;
            OSC_OUTPUT_PIN_OE_N <= 1'b1;
        end else if (retention_supply) begin
            OSC_OUTPUT_PIN_OUT  <= 1'b1;
            OSC_OUTPUT_PIN_OE_N <= 1'b0;
        end else if (!group_sync_n) begin
            OSC_OUTPUT_PIN_OUT  <= !(sync_delayed ? bit_clk : osc_clk);
            OSC_OUTPUT_PIN_OE_N <= 1'b0;
        end else begin
            OSC_OUTPUT_PIN_OUT  <= 1'b0;
            OSC_OUTPUT_PIN_OE_N <= 1'b1;
        end
    end

    // Target clock, supply and reset
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            OSC_INPUT_PIN      <= 1'b0;
            SUPPLY_ON          <= 1'b0;
            SUPPLY_LOW_V       <= 1'b0;
            TARGET_RESET_N_OUT <= 1'b0;
            TARGET_RESET_OE_N  <= 1'b0;
            SKIP_LINE          <= 1'b0;
        end else begin
            OSC_INPUT_PIN      <= osc_clk && supply_and_clock_on;
            SUPPLY_ON          <= supply_and_clock_on || !reset_float_n;
            SUPPLY_LOW_V       <= !reset_float_n;
            TARGET_RESET_N_OUT <= !target_rst_hold;
            TARGET_RESET_OE_N  <= !reset_float_n;
            SKIP_LINE          <= !reset_float_n && TARGET_RESET_IN;
        end
    end

    // Port drivers and the strobe onto D0
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            L_IN_DRIVE_OE_N   <= 1'b1;
            D0_OUT            <= 1'b0;
            D0_OE_N           <= 1'b1;
            SERIAL_BIT_CLOCK  <= 1'b0;
            TESTER_BIT_STROBE <= 1'b0;
        end else begin
            L_IN_DRIVE_OE_N   <= drive_enable_n;
            D0_OUT            <= bit_strobe && second_clock_test;
            D0_OE_N           <= !second_clock_test;
            SERIAL_BIT_CLOCK  <= bit_clk;
            TESTER_BIT_STROBE <= bit_strobe;
        end
    end

    // Mode outputs and tester-memory transfer strobes
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            COMPARE_MODE      <= 1'b0;
            TRANSFER_ACTIVE   <= 1'b0;
            VERIFY_MODE       <= 1'b0;
            TESTER_MEM_WRITE  <= 1'b0;
            TESTER_MEM_VERIFY <= 1'b0;
            TESTER_MEM_DATA   <= 8'h00;
        end else begin
            COMPARE_MODE      <= compare_select;
            TRANSFER_ACTIVE   <= !transfer_mode_n;
            VERIFY_MODE       <= verify_not_write;
            // Transfers pause during board reset; the word bus then carries setup data
            TESTER_MEM_WRITE  <= !board_rst && !transfer_mode_n && !verify_not_write
                                 && bit_strobe;
            TESTER_MEM_VERIFY <= !board_rst && !transfer_mode_n && verify_not_write
                                 && bit_strobe;
            TESTER_MEM_DATA   <= SHARED_DATA;
        end
    end

    // Operator box and handler results
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            GOOD_PART <= 1'b0;
            BAD_PART  <= 1'b0;
            TEST_DONE <= 1'b0;
        end else begin
            GOOD_PART <= !pass_n;
            BAD_PART  <= !fail_n;
            TEST_DONE <= test_done;
        end
    end
endmodule : tcl_latch_bank
`default_nettype wire

// ===== bench/tcl_latch_bank_checker.sv
// Purpose: Port checks of the control latch bank
// Assumes: One clock; host loads with both resets low
// Notes:   Loads gated by the part reset bit are not tracked
`timescale 1ns/10ps
`default_nettype none
module tcl_latch_bank_checker (
    input wire logic        CLOCK,
    input wire logic        ARST_N,
    input wire logic        HOST_TARGET_RESET_N,
    input wire logic        HOST_SYSTEM_RESET_N,
    input wire logic        LATCH_STROBE,
    input wire logic [7:0]  SHARED_DATA,
    input wire logic [10:0] ADDR_OUT,
    input wire logic        ADDR_OE_N,
    input wire logic        TARGET_RESET_N_OUT,
    input wire logic        L_IN_DRIVE_OE_N,
    input wire logic        GOOD_PART,
    input wire logic        BAD_PART,
    input wire logic        TEST_DONE
);
    logic strobe_q, take;
    // Last strobe level, for the rising edge
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) strobe_q <= 1'b0;
        else strobe_q <= LATCH_STROBE;
    end
    // Sure load only; the reset-bit path is left out
    assign take = LATCH_STROBE & ~strobe_q & ~HOST_TARGET_RESET_N & ~HOST_SYSTEM_RESET_N;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    a_addr_pullup: assert property (ADDR_OE_N |-> ADDR_OUT == 11'h7FF)
        else $error("floated address not at pull-up value");
    a_addr_follows: assert property (ADDR_OE_N == !$past(HOST_TARGET_RESET_N))
        else $error("address enable not following board reset");
    a_load_refused: assert property (HOST_TARGET_RESET_N && $past(HOST_TARGET_RESET_N)
        |=> $stable({TEST_DONE, L_IN_DRIVE_OE_N})) else $error("load outside reset");
    // Latch takes the word at the strobe edge, the output flop one edge later
    a_result_load: assert property (take && SHARED_DATA[5:3] == 3'h6
        |-> ##2 {GOOD_PART, BAD_PART, TEST_DONE} == ($past(SHARED_DATA[2:0], 2) ^ 3'h6))
        else $error("result group not loaded");
    a_drive_load: assert property (take && SHARED_DATA[5:3] == 3'h1
        |-> ##2 L_IN_DRIVE_OE_N == $past(SHARED_DATA[2], 2))
        else $error("drive group not loaded");
    a_result_kept: assert property (take && SHARED_DATA[5:3] != 3'h6
        |-> ##2 $stable({GOOD_PART, BAD_PART, TEST_DONE}))
        else $error("result group disturbed");
    a_drive_kept: assert property (take && SHARED_DATA[5:3] != 3'h1
        |-> ##2 $stable(L_IN_DRIVE_OE_N)) else $error("drive group disturbed");
    a_target_held: assert property (!HOST_SYSTEM_RESET_N |=> !TARGET_RESET_N_OUT)
        else $error("target released in host system reset");
endmodule : tcl_latch_bank_checker
`default_nettype wire

// ===== bench/tcl_host_model.sv
// Purpose: Host model that places and strobes the setup word
// Assumes: Host lines change at falling clock edges
// Notes:   Word is seen only at the pull-up address
`timescale 1ns/10ps
`default_nettype none
module tcl_host_model (
    input  wire logic        clock,
    input  wire logic [10:0] addr_out,
    input  wire logic        addr_oe_n,
    output logic             strobe,
    output logic [7:0]       data
);
    logic [7:0] word = 8'h00;
    // Floated lines read all ones; elsewhere a scrambled byte
    assign data = ((addr_oe_n ? 11'h7FF : addr_out) == 11'h7FF) ? word : ~word;
    initial strobe = 1'b0;
    // Word placed, then strobe low, high, low, one cycle each
    task automatic write_word(input logic [7:0] w);
        @(negedge clock);
        word = w;
        @(negedge clock);
        strobe = 1'b1;
        @(negedge clock);
        strobe = 1'b0;
        @(negedge clock);
    endtask : write_word
endmodule : tcl_host_model
`default_nettype wire

// ===== bench/tb_tcl_latch_bank.sv
// Purpose: Self-checking bench for the control latch bank
// Assumes: Inputs change at falling clock edges
// Notes:   Driver queues expected outputs; a monitor compares
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", n, e, s); end end
module tb_tcl_latch_bank;
    logic        clock = 1'b0, arst_n = 1'b0, host_trst_n = 1'b0, host_srst_n = 1'b0;
    logic        trst_in = 1'b0, strobe, addr_oe_n, trst_out, lin_oe_n, skip, sup_on;
    logic        sup_low, good, bad, done, cmp, xfer, ver;
    logic        trst_oe, d0_oe, osc_oe, bclk, bstb, tclk, hs = 1'b0, st = 1'b0, err = 1'b0;
    logic [3:0]  ev;
    logic [7:0]  sdata;
    logic [10:0] addr;
    logic [13:0] exp_v, obs, q [$];
    logic [2:0]  g [8];
    int          seed = 5, bad_count = 0, comparisons = 0;
    event        chk_ev;
    tcl_latch_bank tcl_latch_bank_i (
        .CLOCK(clock), .ARST_N(arst_n), .HOST_TARGET_RESET_N(host_trst_n),
        .HOST_SYSTEM_RESET_N(host_srst_n), .LATCH_STROBE(strobe), .SHARED_DATA(sdata),
        .HALF_SPEED_FLAG_N(hs), .START_SWITCH_STATE(st), .COMPARE_ERROR(err),
        .TARGET_RESET_IN(trst_in), .ADDR_OUT(addr), .ADDR_OE_N(addr_oe_n),
        .OSC_INPUT_PIN(), .OSC_OUTPUT_PIN_OUT(), .OSC_OUTPUT_PIN_OE_N(osc_oe),
        .TARGET_RESET_N_OUT(trst_out), .TARGET_RESET_OE_N(trst_oe), .L_IN_DRIVE_OE_N(lin_oe_n),
        .SERIAL_BIT_CLOCK(bclk), .TESTER_BIT_STROBE(bstb), .D0_OUT(), .D0_OE_N(d0_oe),
        .EVENT_OUT(ev), .TRACE_CLOCK(tclk), .SKIP_LINE(skip), .COMPARE_MODE(cmp),
        .TRANSFER_ACTIVE(xfer),
        .VERIFY_MODE(ver), .TESTER_MEM_WRITE(), .TESTER_MEM_VERIFY(), .TESTER_MEM_DATA(),
        .SUPPLY_ON(sup_on), .SUPPLY_LOW_V(sup_low), .GOOD_PART(good), .BAD_PART(bad),
        .TEST_DONE(done));
    tcl_host_model tcl_host_model_i (.clock(clock), .addr_out(addr), .addr_oe_n(addr_oe_n),
        .strobe(strobe), .data(sdata));
    assign obs = {lin_oe_n, cmp, xfer, ver, sup_on, sup_low, good, bad, done, trst_out, skip,
        trst_oe, d0_oe, osc_oe};
    always #25 clock = ~clock;
    // Expected outputs from the group image
    task automatic note();
        q.push_back({g[1][2], g[2][2], !g[4][1], g[4][0], g[5][1] | !g[7][1], !g[7][1],
            !g[6][2], !g[6][1], g[6][0], g[3][2] & host_srst_n, !g[7][1] & trst_in,
            !g[7][1], !g[5][0], g[1][1] | (!g[5][2] & g[2][0])});
        ->chk_ev;
    endtask : note
    // One setup word; ok says whether it should be taken
    task automatic put(input logic [7:0] w, input logic ok);
        tcl_host_model_i.write_word(w);
        if (ok) g[w[5:3]] = w[2:0];
        note();
    endtask : put
    // Reset pulse, then reset image and floated address
    task automatic rst();
        arst_n = 1'b0;
        repeat (20) @(negedge clock);
        arst_n = 1'b1;
        for (int i = 0; i < 8; i++) g[i] = tcl_pkg::LATCH_RESET[i*3 +: 3];
        @(negedge clock);
        note();
        `CHK("address", 12'hFFF, {addr_oe_n, addr})
    endtask : rst
    // Strobe lag and bit period at the fastest oscillator; divide by 8 keeps
    // the slow strobe clear of the next bit clock rise
    task automatic timing(input logic slow);
        int n;
        put(8'h04, 1'b1);
        put(8'h1A, 1'b1);
        put({5'h07, slow, 2'h0}, 1'b1);
        put(8'h2A, 1'b1);
        @(negedge clock iff !bclk);
        @(negedge clock iff bclk);
        n = 0;
        while (!bstb) begin
            n++;
            @(negedge clock);
        end
        `CHK("strobe delay", slow ? tcl_pkg::STROBE_SLOW_CYC : tcl_pkg::STROBE_FAST_CYC, n)
        n = 0;
        do begin
            n++;
            @(negedge clock);
        end while (!bstb);
        `CHK("bit period", tcl_pkg::OSC_PER_4 * tcl_pkg::DIV_8, n)
    endtask : timing
    // Oldest note against the outputs now
    always @(chk_ev) begin
        exp_v = q.pop_front();
        `CHK("outputs", exp_v, obs)
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    // Every code of every group, then random words
    initial begin
        rst();
        for (int i = 0; i < 64; i++) put({2'h3, 6'(i)}, 1'b1);
        for (int i = 0; i < 24; i++) begin
            trst_in = 1'($random(seed));
            put(8'($random(seed)), 1'b1);
        end
        for (int s = 0; s < 2; s++) timing(1'(s));
        host_trst_n = 1'b1;
        @(negedge clock);
        `CHK("address enable", 1'b0, addr_oe_n)
        put(8'h37, 1'b0);
        host_trst_n = 1'b0;
        put(8'h1C, 1'b1);
        host_srst_n = 1'b1;
        put(8'h30, 1'b0);
        host_srst_n = 1'b0;
        put(8'h30, 1'b1);
        rst();
        put(8'h0B, 1'b1);
        // Second routing with timing stopped: inputs pass, trace clock idles high
        repeat (4) begin
            {hs, st, err} = 3'($random(seed));
            @(negedge clock);
            `CHK("events", {hs, 1'b0, st, err, 1'b1}, {ev, tclk})
        end
        report_and_stop();
    end
    // Sequence needs well under 1000 cycles
    initial begin
        #(tcl_pkg::CLOCK_PERIOD_NS * 4000);
        bad_count++;
        report_and_stop();
    end
endmodule : tb_tcl_latch_bank
bind tcl_latch_bank tcl_latch_bank_checker tcl_latch_bank_checker_i (.CLOCK, .ARST_N,
    .HOST_TARGET_RESET_N, .HOST_SYSTEM_RESET_N, .LATCH_STROBE, .SHARED_DATA, .ADDR_OUT,
    .ADDR_OE_N, .TARGET_RESET_N_OUT, .L_IN_DRIVE_OE_N, .GOOD_PART, .BAD_PART, .TEST_DONE);
`default_nettype wire
